// *** core/dcsw_pkg.sv ***
// Package for the drive command/state word interpreter.
// Assumes a single 25 MHz clock domain and a plain strobe register port.
package dcsw_pkg;

	// Register word indices on the plain port
	localparam logic [3:0] DCSW_ADDR_CMD     = 4'h0; // Command word, write
	localparam logic [3:0] DCSW_ADDR_STATE   = 4'h1; // State word, read
	localparam logic [3:0] DCSW_ADDR_SPDREF  = 4'h2; // Speed reference, read and write
	localparam logic [3:0] DCSW_ADDR_ACTFREQ = 4'h3; // Actual frequency, read
	localparam logic [3:0] DCSW_ADDR_CFG     = 4'h4; // Gating and option config
	localparam logic [3:0] DCSW_ADDR_ACTION  = 4'h5; // Decoded actions, read

	// Command word bit positions
	localparam int unsigned CB_REF_LO  = 0;
	localparam int unsigned CB_DCBRK_N = 2;
	localparam int unsigned CB_COAST_N = 3;
	localparam int unsigned CB_QSTOP_N = 4;
	localparam int unsigned CB_HOLD_N  = 5;
	localparam int unsigned CB_START   = 6;
	localparam int unsigned CB_RESET   = 7;
	localparam int unsigned CB_JOG     = 8;
	localparam int unsigned CB_RAMP2   = 9;
	localparam int unsigned CB_VALID   = 10;
	localparam int unsigned CB_RELAY1  = 11;
	localparam int unsigned CB_RELAY2  = 12;
	localparam int unsigned CB_SETUP_LO = 13;
	localparam int unsigned CB_REVERSE = 15;

	// Config register field positions
	localparam int unsigned CF_REF_GATE   = 0;  // 2 bits
	localparam int unsigned CF_COAST_GATE = 2;  // 2 bits
	localparam int unsigned CF_START_GATE = 4;  // 2 bits
	localparam int unsigned CF_SETUP_GATE = 6;  // 2 bits
	localparam int unsigned CF_REV_GATE   = 8;  // 2 bits
	localparam int unsigned CF_RELAY1_CW  = 10;
	localparam int unsigned CF_RELAY2_CW  = 11;
	localparam int unsigned CF_MULTI_SETUP = 12;

	// Reset values
	localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
	localparam logic [15:0] CFG_RESET_VAL = 16'h0000; // Reversing from digital input
	localparam logic [15:0] REF_RESET_VAL = 16'h0000;
	localparam logic [15:0] REF_FULL_SCALE = 16'h4000; // 100 percent

	// Gating selections for combining a command bit with a digital input
	typedef enum logic [1:0] {
		DCSW_GATE_DIN = 2'h0,
		DCSW_GATE_BUS = 2'h1,
		DCSW_GATE_AND = 2'h2,
		DCSW_GATE_OR  = 2'h3
	} dcsw_gate_t;

	// Digital input functions
	typedef struct packed {
		logic [1:0] ref_sel;
		logic       coast_n;
		logic       start;
		logic [1:0] setup_sel;
		logic       reverse;
		logic       dc_brake;
		logic       coast_stop;
		logic       reset_coast;
	} dcsw_din_t;

	// Drive condition inputs feeding the state word
	typedef struct packed {
		logic control_ready;
		logic drive_ready;
		logic trip;
		logic error_no_trip;
		logic trip_lock;
		logic warning;
		logic speed_at_ref;
		logic bus_ctrl_ok;
		logic freq_in_limit;
		logic running;
		logic overtemp_hold;
		logic dc_volt_bad;
		logic current_limit;
		logic thermal_over;
		logic link_fault;
	} dcsw_cond_t;

	// Decoded drive actions
	typedef struct packed {
		logic [1:0] ref_index;
		logic       dc_brake;
		logic       coast;
		logic       quick_stop;
		logic       freeze;
		logic       ramp_stop;
		logic       start_ok;
		logic       jog;
		logic       ramp_set2;
		logic       relay1;
		logic       relay2;
		logic [1:0] setup;
		logic       reverse;
	} dcsw_act_t;

endpackage : dcsw_pkg

// *** core/dcsw_core.sv ***
// Command word interpreter and state word builder for a drive.
// Assumes software on the 25 MHz clock drives the strobe port; digital
// inputs and drive conditions arrive asynchronously and are synchronised.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Command bits 1:0 pick one of four preset references.
// - Bit 2 low applies DC brake and stop; high ramps normally.
// - Bit 3 low coasts at once; high allows start.
// - Bit 4 low performs quick stop on quick-stop ramp.
// - Bit 5 low freezes output frequency.
// - Frozen output stops only by coast, DC brake or matching inputs.
// - Bit 6 low ramps to stop; high permits start.
// - Trip reset only on rising edge of bit 7.
// - Bit 8 high selects jog speed.
// - Bit 9 selects ramp set 1 or 2.
// - Whole word ignored while bit 10 is low.
// - Bits 11, 12 drive relays only when relay follows the word.
// - Bits 14:13 select set-up when multi set-up enabled.
// - Bit 15 reverses only with bus, OR or AND reversing source.
// - Reference, coast, start, set-up combine with inputs per gating.
// - State bits 0..2: control ready, drive ready, start enabled.
// - State bits 3,4,6 flag trip, error, triplock; bit 5 zero.
// - State bits 7,13,14,15 flag warning, voltage, current, thermal.
// - State bits 8..11 flag at-speed, bus control, limits, running or start permitted.
// - State bit 12 flags over-temperature hold with auto restart.
// - Link fault forces whole state word to zero.
// - Reference and frequency are signed with 0x4000 as 100 percent.
module dcsw_core
	import dcsw_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic [3:0]  addr_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire dcsw_din_t   din_i,
	input  wire dcsw_cond_t  cond_i,
	input  wire logic [15:0] act_freq_i,
	output logic      [15:0] rdata_o,
	output dcsw_act_t        act_o,
	output logic             trip_reset_o,
	output logic      [15:0] speed_ref_o
);

	// Registers and synchronisers
	logic [15:0] cmd_q;
	logic [15:0] cfg_q;
	logic [15:0] ref_q;
	logic        reset_bit_q;
	dcsw_din_t   din_s1_q, din_s2_q;
	dcsw_cond_t  cond_s1_q, cond_s2_q;
	logic [15:0] afq_s1_q, afq_s2_q;
	dcsw_act_t   act_d;
	logic [15:0] state_d;

	// Combine one bus bit with its input function per gating choice
	function automatic logic gate_bit(input logic [1:0] sel, input logic bus_b,
		input logic din_b);
		unique case (dcsw_gate_t'(sel))
			DCSW_GATE_DIN: gate_bit = din_b;
			DCSW_GATE_BUS: gate_bit = bus_b;
			DCSW_GATE_AND: gate_bit = bus_b & din_b;
			DCSW_GATE_OR:  gate_bit = bus_b | din_b;
		endcase
	endfunction : gate_bit

	// Two-stage synchronisers for asynchronous inputs
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			din_s1_q  <= '0;
			din_s2_q  <= '0;
			cond_s1_q <= '0;
			cond_s2_q <= '0;
			afq_s1_q  <= '0;
			afq_s2_q  <= '0;
		end else begin
			din_s1_q  <= din_i;
			din_s2_q  <= din_s1_q;
			cond_s1_q <= cond_i;
			cond_s2_q <= cond_s1_q;
			afq_s1_q  <= act_freq_i; // Sampled word may tear; producer holds it steady
			afq_s2_q  <= afq_s1_q;
		end
	end

	// Command word is taken only while its valid bit is set
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			cmd_q <= CMD_RESET_VAL;
		end else if (wr_i && addr_i == DCSW_ADDR_CMD && wdata_i[CB_VALID]) begin
			cmd_q <= wdata_i;
		end
	end

	// Config and speed reference registers
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			cfg_q <= CFG_RESET_VAL;
			ref_q <= REF_RESET_VAL;
		end else if (wr_i) begin
			if (addr_i == DCSW_ADDR_CFG) begin
				cfg_q <= wdata_i;
			end
			if (addr_i == DCSW_ADDR_SPDREF) begin
				ref_q <= wdata_i;
			end
		end
	end

	// Decode actions from the held command word and inputs
	always_comb begin
		logic frz;
		logic stop_by_ramp;
		frz = 1'b0;
		stop_by_ramp = 1'b0;
		act_d = '0;
		act_d.ref_index[0] = gate_bit(cfg_q[CF_REF_GATE +: 2], cmd_q[CB_REF_LO],
			din_s2_q.ref_sel[0]);
		act_d.ref_index[1] = gate_bit(cfg_q[CF_REF_GATE +: 2], cmd_q[CB_REF_LO + 1],
			din_s2_q.ref_sel[1]);
		act_d.dc_brake = ~cmd_q[CB_DCBRK_N] | din_s2_q.dc_brake;
		act_d.coast = ~gate_bit(cfg_q[CF_COAST_GATE +: 2], cmd_q[CB_COAST_N],
			din_s2_q.coast_n) | din_s2_q.coast_stop | din_s2_q.reset_coast;
		frz = ~cmd_q[CB_HOLD_N];
		act_d.freeze = frz;
		// Frozen output ignores quick stop and ramp stop
		act_d.quick_stop = ~cmd_q[CB_QSTOP_N] & ~frz;
		stop_by_ramp = ~gate_bit(cfg_q[CF_START_GATE +: 2], cmd_q[CB_START],
			din_s2_q.start);
		act_d.ramp_stop = stop_by_ramp & ~frz;
		act_d.start_ok = ~stop_by_ramp & ~act_d.coast & ~act_d.dc_brake
			& ~act_d.quick_stop;
		act_d.jog = cmd_q[CB_JOG];
		act_d.ramp_set2 = cmd_q[CB_RAMP2];
		act_d.relay1 = cmd_q[CB_RELAY1] & cfg_q[CF_RELAY1_CW];
		act_d.relay2 = cmd_q[CB_RELAY2] & cfg_q[CF_RELAY2_CW];
		if (cfg_q[CF_MULTI_SETUP]) begin
			act_d.setup[0] = gate_bit(cfg_q[CF_SETUP_GATE +: 2], cmd_q[CB_SETUP_LO],
				din_s2_q.setup_sel[0]);
			act_d.setup[1] = gate_bit(cfg_q[CF_SETUP_GATE +: 2], cmd_q[CB_SETUP_LO + 1],
				din_s2_q.setup_sel[1]);
		end
		act_d.reverse = gate_bit(cfg_q[CF_REV_GATE +: 2], cmd_q[CB_REVERSE],
			din_s2_q.reverse);
	end

	// State word assembly; a link fault blanks every bit
	always_comb begin
		state_d = '0;
		if (!cond_s2_q.link_fault) begin
			state_d[0]  = cond_s2_q.control_ready & ~cond_s2_q.trip;
			state_d[1]  = cond_s2_q.drive_ready;
			state_d[2]  = ~act_d.coast;
			state_d[3]  = cond_s2_q.trip;
			state_d[4]  = cond_s2_q.error_no_trip;
			state_d[6]  = cond_s2_q.trip_lock;
			state_d[7]  = cond_s2_q.warning;
			state_d[8]  = cond_s2_q.speed_at_ref;
			state_d[9]  = cond_s2_q.bus_ctrl_ok;
			state_d[10] = cond_s2_q.freq_in_limit;
			state_d[11] = cond_s2_q.running | act_d.start_ok;
			state_d[12] = cond_s2_q.overtemp_hold;
			state_d[13] = cond_s2_q.dc_volt_bad;
			state_d[14] = cond_s2_q.current_limit;
			state_d[15] = cond_s2_q.thermal_over;
		end
	end

	// Action outputs and speed reference registered
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			act_o       <= '0;
			speed_ref_o <= REF_RESET_VAL;
		end else begin
			act_o       <= act_d;
			speed_ref_o <= ref_q;
		end
	end

	// Reset pulse on leading edge of bit 7; a held level never repeats it
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			reset_bit_q  <= 1'b0;
			trip_reset_o <= 1'b0;
		end else begin
			reset_bit_q  <= cmd_q[CB_RESET];
			trip_reset_o <= cmd_q[CB_RESET] & ~reset_bit_q;
		end
	end

	// Read data valid in the cycle after the read strobe only
	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			unique case (addr_i)
				DCSW_ADDR_STATE:   rdata_o <= state_d;
				DCSW_ADDR_ACTFREQ: rdata_o <= afq_s2_q;
				DCSW_ADDR_CFG:     rdata_o <= cfg_q;
				DCSW_ADDR_SPDREF:  rdata_o <= ref_q;
				DCSW_ADDR_ACTION:  rdata_o <= {1'b0, act_d}; // Actions are 15 bits wide
				default:           rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

	// Checks: an invalid command write leaves the held word alone
	AST_VALID_GATE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(wr_i && addr_i == DCSW_ADDR_CMD && !wdata_i[CB_VALID]) |=> $stable(cmd_q))
		else $error("Command word changed without valid bit");

	// A valid command write lands on the next edge
	AST_VALID_TAKE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(wr_i && addr_i == DCSW_ADDR_CMD && wdata_i[CB_VALID]) |=> cmd_q == $past(wdata_i))
		else $error("Valid command word not taken");

	// Trip reset follows only a 0 to 1 step of bit 7
	AST_RESET_EDGE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		trip_reset_o |-> $past(cmd_q[CB_RESET], 1) && !$past(cmd_q[CB_RESET], 2))
		else $error("Trip reset without rising edge");

	// Trip reset is a single-cycle pulse
	AST_RESET_PULSE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		trip_reset_o |=> !trip_reset_o)
		else $error("Trip reset longer than one cycle");

	// DC brake command blocks any start
	AST_DC_BRAKE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!cmd_q[CB_DCBRK_N] |=> act_o.dc_brake && !act_o.start_ok)
		else $error("DC brake not applied");

	// Frozen output ignores quick stop and ramp stop
	AST_FREEZE: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!cmd_q[CB_HOLD_N] |=> act_o.freeze && !act_o.quick_stop && !act_o.ramp_stop)
		else $error("Frozen output stopped by ramp");

	// Relay 1 stays off unless it follows the command word
	AST_RELAY: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!cfg_q[CF_RELAY1_CW] |=> !act_o.relay1)
		else $error("Relay driven without config");

	// Relay 2 stays off unless it follows the command word
	AST_RELAY2: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!cfg_q[CF_RELAY2_CW] |=> !act_o.relay2)
		else $error("Second relay driven without config");

	// Set-up select is held at the first set-up without multi set-up
	AST_SETUP: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!cfg_q[CF_MULTI_SETUP] |=> act_o.setup == 2'h0)
		else $error("Set-up changed without multi set-up");

	// Link fault blanks the whole state word
	AST_LINK_LOSS: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && cond_s2_q.link_fault) |=> rdata_o == 16'h0000)
		else $error("State word not blanked on link fault");

	// Unused state bit always reads zero
	AST_BIT5: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE) |=> !rdata_o[5])
		else $error("Unused state bit set");

	// Bus-gated reference index copies command bits 1:0
	AST_REF_SELECT: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_q[CF_REF_GATE +: 2] == DCSW_GATE_BUS)
		|=> act_o.ref_index == $past(cmd_q[CB_REF_LO +: 2]))
		else $error("Reference index does not follow command");

	// Bus-gated coast command releases the motor and blocks start
	AST_COAST_BUS: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_q[CF_COAST_GATE +: 2] == DCSW_GATE_BUS && !cmd_q[CB_COAST_N])
		|=> act_o.coast && !act_o.start_ok)
		else $error("Coast command not applied");

	// Quick stop acts when the output is not frozen
	AST_QUICK_STOP: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(!cmd_q[CB_QSTOP_N] && cmd_q[CB_HOLD_N]) |=> act_o.quick_stop)
		else $error("Quick stop not applied");

	// Coasting stop input still stops a frozen output
	AST_FREEZE_COAST: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(!cmd_q[CB_HOLD_N] && din_s2_q.coast_stop) |=> act_o.coast)
		else $error("Coast input ignored while frozen");

	// Bus-gated ramp stop acts when not frozen
	AST_RAMP_STOP: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_q[CF_START_GATE +: 2] == DCSW_GATE_BUS && !cmd_q[CB_START] && cmd_q[CB_HOLD_N])
		|=> act_o.ramp_stop && !act_o.start_ok)
		else $error("Ramp stop not applied");

	// Jog follows bit 8 one cycle later
	AST_JOG: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		act_o.jog == $past(cmd_q[CB_JOG]))
		else $error("Jog does not follow command");

	// Ramp set follows bit 9 one cycle later
	AST_RAMP_SET: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		act_o.ramp_set2 == $past(cmd_q[CB_RAMP2]))
		else $error("Ramp set does not follow command");

	// With the input as reversing source the bus bit has no effect
	AST_REVERSE_DIN: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_q[CF_REV_GATE +: 2] == DCSW_GATE_DIN)
		|=> act_o.reverse == $past(din_s2_q.reverse))
		else $error("Reverse not taken from input");

	// Input-gated start with the input low never permits a start
	AST_GATE_DIN: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(cfg_q[CF_START_GATE +: 2] == DCSW_GATE_DIN && !din_s2_q.start)
		|=> !act_o.start_ok)
		else $error("Start permitted without input");

	// Trip clears control ready and raises the trip flag
	AST_STATE_READY: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && !cond_s2_q.link_fault && cond_s2_q.trip)
		|=> !rdata_o[0] && rdata_o[3])
		else $error("Trip not shown in state word");

	// Error and lock flags mirror their conditions
	AST_STATE_ERROR: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && !cond_s2_q.link_fault)
		|=> rdata_o[4] == $past(cond_s2_q.error_no_trip)
		&& rdata_o[6] == $past(cond_s2_q.trip_lock))
		else $error("Error flags wrong in state word");

	// Warning, voltage, current and thermal flags mirror their conditions
	AST_STATE_WARN: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && !cond_s2_q.link_fault)
		|=> rdata_o[7] == $past(cond_s2_q.warning)
		&& rdata_o[13] == $past(cond_s2_q.dc_volt_bad)
		&& rdata_o[14] == $past(cond_s2_q.current_limit)
		&& rdata_o[15] == $past(cond_s2_q.thermal_over))
		else $error("Warning flags wrong in state word");

	// Speed and bus control flags mirror their conditions
	AST_STATE_SPEED: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && !cond_s2_q.link_fault)
		|=> rdata_o[8] == $past(cond_s2_q.speed_at_ref)
		&& rdata_o[9] == $past(cond_s2_q.bus_ctrl_ok))
		else $error("Speed flags wrong in state word");

	// Over-temperature hold flag mirrors its condition
	AST_STATE_HOLD: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		(rd_i && addr_i == DCSW_ADDR_STATE && !cond_s2_q.link_fault)
		|=> rdata_o[12] == $past(cond_s2_q.overtemp_hold))
		else $error("Hold flag wrong in state word");

	// Speed reference output copies the register one cycle later
	AST_SPEED_COPY: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		speed_ref_o == $past(ref_q))
		else $error("Speed reference output lags");

	// Main scenarios
	COV_RESET: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) trip_reset_o);
	COV_JOG: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) act_o.jog);
	COV_LINK: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		rd_i && cond_s2_q.link_fault);
	COV_FREEZE: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) act_o.freeze);
	COV_SETUP: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
		act_o.setup == 2'h3);

endmodule : dcsw_core

`default_nettype wire

// *** tb/dcsw_master_model.sv ***
// Register-port master standing in for the fieldbus side of the core.
// Assumes the core samples strobes on the rising edge and never stalls.
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model (
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	output logic      [3:0]  addr_o,
	output logic      [15:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o
);
	// Idle bus at time zero
	initial begin
		addr_o = 4'h0;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One-cycle write; the word is sent exactly as given, bit 10 included
	task automatic write_word(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_o <= 1'b1;
		addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d; // Released data scrambled so stale values never help
	endtask : write_word
	// Read data stands only in the cycle after the strobe; words are signed
	task automatic read_word(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		rd_o <= 1'b1;
		addr_o <= a;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 d = rdata_i;
	endtask : read_word
endmodule : dcsw_master_model
`default_nettype wire

// *** tb/dcsw_core_bench.sv ***
// Self-checking bench for the command/state word core.
// Assumes the master model file is compiled first.
`timescale 1ns/1ps
`default_nettype none
module dcsw_core_bench
	import dcsw_pkg::*;
;
	logic ref_clk_i, resetn_i, wr, rd;
	logic [3:0] addr;
	logic [15:0] wdata, rdata, act_freq, speed_ref, v;
	dcsw_din_t din;
	dcsw_cond_t cond;
	dcsw_act_t act;
	logic trip_rst;
	int n_errors, checks_done;
	localparam logic [15:0] BASE = 16'h047c; // Run bits high, word valid

	dcsw_master_model u_dcsw_master_model (.clk_i(ref_clk_i), .rdata_i(rdata),
		.addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	dcsw_core u_dcsw_core (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .din_i(din), .cond_i(cond),
		.act_freq_i(act_freq), .rdata_o(rdata), .act_o(act), .trip_reset_o(trip_rst),
		.speed_ref_o(speed_ref));

	// 25 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop

	// Command write, then one more edge so the decoded actions have landed
	task automatic wcmd(input logic [15:0] d);
		u_dcsw_master_model.write_word(DCSW_ADDR_CMD, d);
		@(posedge ref_clk_i);
		#1;
	endtask : wcmd

	task automatic wcfg(input logic [15:0] d);
		u_dcsw_master_model.write_word(DCSW_ADDR_CFG, d);
	endtask : wcfg

	// State word from the conditions, coast and start being known from the command
	function automatic logic [15:0] sw(input dcsw_cond_t c, input logic cs, input logic st);
		if (c.link_fault) return 16'h0000;
		return {c.thermal_over, c.current_limit, c.dc_volt_bad, c.overtemp_hold,
			c.running | st, c.freq_in_limit, c.bus_ctrl_ok, c.speed_at_ref, c.warning,
			c.trip_lock, 1'b0, c.error_no_trip, c.trip, ~cs, c.drive_ready,
			c.control_ready & ~c.trip};
	endfunction : sw

	task automatic t_reset;
		chk("trip_reset", 16'h0000, {15'h0, trip_rst});
		chk("speed_ref", REF_RESET_VAL, speed_ref);
		u_dcsw_master_model.read_word(DCSW_ADDR_CFG, v);
		chk("cfg", CFG_RESET_VAL, v);
	endtask : t_reset

	task automatic t_valid;
		wcfg(16'h1d55);
		wcmd(16'h0580);
		chk("jog", 16'h0001, {15'h0, act.jog});
		chk("trip_reset", 16'h0001, {15'h0, trip_rst});
		@(posedge ref_clk_i);
		#1 chk("trip_reset", 16'h0000, {15'h0, trip_rst});
		wcmd(16'h0580);
		chk("trip_reset", 16'h0000, {15'h0, trip_rst});
		wcmd(16'h0000);
		chk("jog", 16'h0001, {15'h0, act.jog});
		wcmd(16'h0400);
		chk("jog", 16'h0000, {15'h0, act.jog});
	endtask : t_valid

	task automatic t_select;
		for (int i = 0; i < 4; i++) begin
			wcmd(BASE | 16'(i) | 16'(i << 13));
			chk("ref_index", 16'(i), {14'h0, act.ref_index});
			chk("setup", 16'(i), {14'h0, act.setup});
		end
	endtask : t_select

	// Each active-low stop bit cleared alone must raise only its own action
	task automatic t_bits;
		for (int b = 2; b < 7; b++) begin
			wcmd(BASE ^ 16'(1 << b));
			chk("stop_set", 16'(5'b10000 >> (b - 2)), {11'h0, act.dc_brake, act.coast,
				act.quick_stop, act.freeze, act.ramp_stop});
			chk("start_ok", 16'(b == 5), {15'h0, act.start_ok});
		end
		wcmd(BASE & 16'hffcf);
		chk("freeze_qs", 16'h0002, {11'h0, act.dc_brake, act.coast,
			act.quick_stop, act.freeze, act.ramp_stop});
		wcmd(BASE & 16'hffd7);
		chk("freeze_coast", 16'h000a, {11'h0, act.dc_brake, act.coast,
			act.quick_stop, act.freeze, act.ramp_stop});
		wcmd(BASE | 16'h0200);
		chk("ramp_set2", 16'h0001, {15'h0, act.ramp_set2});
	endtask : t_bits

	task automatic t_opts;
		wcmd(16'hfc7c);
		chk("relays", 16'h0003, {14'h0, act.relay1, act.relay2});
		chk("reverse", 16'h0001, {15'h0, act.reverse});
		wcfg(16'h0055);
		wcmd(16'hfc7c);
		chk("relays", 16'h0000, {14'h0, act.relay1, act.relay2});
		chk("setup", 16'h0000, {14'h0, act.setup});
		chk("reverse", 16'h0000, {15'h0, act.reverse});
		wcfg(16'h0051);
		wcmd(BASE & 16'hfff7);
		chk("coast_din", 16'h0000, {15'h0, act.coast});
		wcfg(16'h1d55);
	endtask : t_opts

	task automatic t_state;
		dcsw_cond_t pat [4] = '{15'h7ffe, 15'h5554, 15'h2aaa, 15'h7fff};
		wcmd(16'h043c);
		foreach (pat[i]) begin
			@(posedge ref_clk_i);
			cond <= pat[i];
			repeat (4) @(posedge ref_clk_i);
			u_dcsw_master_model.read_word(DCSW_ADDR_STATE, v);
			chk("state", sw(pat[i], 1'b0, 1'b0), v);
		end
	endtask : t_state

	task automatic t_speed;
		u_dcsw_master_model.write_word(DCSW_ADDR_SPDREF, REF_FULL_SCALE);
		u_dcsw_master_model.read_word(DCSW_ADDR_SPDREF, v);
		chk("speed_ref", REF_FULL_SCALE, v);
		u_dcsw_master_model.write_word(DCSW_ADDR_SPDREF, 16'hc000);
		@(posedge ref_clk_i);
		#1 chk("speed_ref", 16'hc000, speed_ref);
		u_dcsw_master_model.read_word(DCSW_ADDR_ACTFREQ, v);
		chk("act_freq", 16'h8001, v);
		u_dcsw_master_model.read_word(4'hf, v);
		chk("unmapped", 16'h0000, v);
	endtask : t_speed

	// Main sequence
	initial begin
		n_errors = 0;
		checks_done = 0;
		resetn_i = 1'b0;
		din = 10'h080; // Input coast released, all else idle
		cond = 15'h0000;
		act_freq = 16'h8001;
		repeat (6) @(posedge ref_clk_i);
		resetn_i <= 1'b1;
		@(posedge ref_clk_i);
		#1 t_reset;
		t_valid;
		t_select;
		t_bits;
		t_opts;
		t_state;
		t_speed;
		report_and_stop;
	end

	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		n_errors++;
		report_and_stop;
	end
endmodule : dcsw_core_bench
`default_nettype wire
